// ===== tbr_top.sv
`timescale 1ns/1ps
module tbr_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// trace capture from the debug unit
	input wire logic trc_valid,
	input wire logic [tbr_pkg::TBR_PC_W-1:0] trc_pc,
	input wire logic trc_dest,
	input wire logic trc_vec,
	input wire logic session_end,
	// security pin
	input wire logic secured
);
	import tbr_pkg::*;

	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [3:0] ctrl_q;
	logic sec_m_q;
	logic sec_s_q;
	logic unlocked_q;
	logic [TBR_AW-1:0] rd_ptr_q;
	logic half_q;
	logic [TBR_AW-1:0] wr_ptr_q;
	logic [TBR_CW-1:0] count_q;
	logic wrapped_q;
	logic [TBR_PC_W-1:0] last_pc_q;
	logic last_ok_q;
	// set by the first session; before it the line count is still unknown
	logic filled_q;

	logic acc;
	logic done;
	logic aligned;
	logic full_wr;
	logic mapped;
	logic arm;
	logic tsrc;
	logic [1:0] mode;
	logic rd_ok;
	logic sess_start;
	logic unlock;
	logic rewind;
	logic advance;
	logic [TBR_AW-1:0] oldest;
	logic [31:0] rd_val;
	logic cap;
	logic dup_src;
	logic norm_we;
	logic cmp_we;
	logic cmp_new;
	logic [TBR_ROW_W-1:0] cmp_row;
	logic [TBR_ROW_W-1:0] norm_row;
	logic row_we;
	logic row_new;
	logic [TBR_ROW_W-1:0] row;

	tbr_mem_if #(.W(TBR_ROW_W), .AW(TBR_AW)) mif ();

	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;

	assign arm = ctrl_q[TBR_CTRL_ARM];
	assign tsrc = ctrl_q[TBR_CTRL_TSRC];
	assign mode = ctrl_q[TBR_CTRL_MODE +: 2];

	// one wait state: data is sampled in the first access cycle
	assign acc = psel && penable && !pready_q;
	assign done = psel && penable && pready_q;
	assign aligned = paddr[1:0] == 2'h0;
	assign full_wr = pstrb == 4'hf;
	assign mapped = aligned && (paddr == TBR_OFF_CTRL || paddr == TBR_OFF_STAT
		|| paddr == TBR_OFF_DATA || paddr == TBR_OFF_DATA_UP);

	// security pin comes from outside the clock domain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_m_q <= 1'b1;
			sec_s_q <= 1'b1;
		end else begin
			sec_m_q <= secured;
			sec_s_q <= sec_m_q;
		end
	end

	assign rd_ok = unlocked_q && !arm && tsrc && !sec_s_q;
	assign oldest = wrapped_q ? wr_ptr_q : '0;

	assign sess_start = done && pwrite && paddr == TBR_OFF_CTRL && pstrb[0]
		&& pwdata[TBR_CTRL_ARM];
	assign rewind = done && pwrite && full_wr && aligned
		&& (paddr == TBR_OFF_DATA || paddr == TBR_OFF_DATA_UP);
	assign unlock = rewind && !arm;
	assign advance = done && !pwrite && paddr == TBR_OFF_DATA && rd_ok;

	// buffer word select; only the lower data port delivers contents
	always_comb begin
		rd_val = 32'h0000_0000;
		if (paddr == TBR_OFF_DATA && tsrc && rd_ok) begin
			if (half_q) begin
				rd_val = {28'h000_0000, mif.rdata[19:16]};
			end else begin
				rd_val = {16'h0000, mif.rdata[15:0]};
			end
		end else if (paddr == TBR_OFF_CTRL) begin
			rd_val = {28'h000_0000, ctrl_q};
		end else if (paddr == TBR_OFF_STAT) begin
			rd_val[TBR_CW-1:0] = count_q;
			rd_val[TBR_STAT_WRAP] = wrapped_q;
			rd_val[TBR_STAT_UNLK] = unlocked_q;
			rd_val[TBR_STAT_ARM] = arm;
		end
	end

	// apb answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= acc;
			pslverr_q <= acc && !mapped;
			if (acc && !pwrite && mapped) begin
				prdata_q <= rd_val;
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	// control register; a software write beats the session end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= TBR_CTRL_RST;
		end else if (done && pwrite && paddr == TBR_OFF_CTRL && pstrb[0]) begin
			ctrl_q <= pwdata[3:0];
		end else if (session_end) begin
			ctrl_q[TBR_CTRL_ARM] <= 1'b0;
		end
	end

	// read lock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unlocked_q <= 1'b0;
		end else if (sess_start) begin
			unlocked_q <= 1'b0;
		end else if (unlock) begin
			unlocked_q <= 1'b1;
		end
	end

	// read pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_ptr_q <= '0;
			half_q <= 1'b0;
		end else if (rewind) begin
			rd_ptr_q <= oldest;
			half_q <= 1'b0;
		end else if (advance) begin
			half_q <= !half_q;
			if (half_q) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
		end
	end

	// capture while armed
	assign cap = arm && trc_valid && !sess_start;
	// loop1 drops only a source address that repeats the last stored address
	assign dup_src = mode == TBR_MODE_LOOP1 && !trc_dest && !trc_vec
		&& last_ok_q && trc_pc == last_pc_q;
	assign norm_we = cap && mode != TBR_MODE_COMP && !dup_src;
	always_comb begin
		norm_row = {2'h0, trc_pc};
		norm_row[TBR_INF_SRCDST] = trc_dest || trc_vec;
		norm_row[TBR_INF_VEC] = trc_vec;
	end

	tbr_cmp u_cmp (
		.clk(pclk),
		.rst_n(presetn),
		.start(sess_start),
		.valid(cap && mode == TBR_MODE_COMP),
		.pc(trc_pc),
		.at_line0(wr_ptr_q == '0),
		.we(cmp_we),
		.new_line(cmp_new),
		.row(cmp_row)
	);

	assign row_we = norm_we || cmp_we;
	assign row_new = norm_we || cmp_new;
	assign row = norm_we ? norm_row : cmp_row;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_ok_q <= 1'b0;
		end else if (sess_start) begin
			last_ok_q <= 1'b0;
		end else if (norm_we) begin
			last_ok_q <= 1'b1;
		end
	end

	always_ff @(posedge pclk) begin
		if (norm_we) begin
			last_pc_q <= trc_pc;
		end
	end

	// fill state has no reset: a system reset must not lose the session
	always_ff @(posedge pclk) begin
		if (sess_start) begin
			filled_q <= 1'b1;
			wr_ptr_q <= '0;
			count_q <= '0;
			wrapped_q <= 1'b0;
		end else if (row_we && row_new) begin
			wr_ptr_q <= wr_ptr_q + 1'b1;
			if (count_q != TBR_CW'(2**TBR_AW)) begin
				count_q <= count_q + 1'b1;
			end
			if (wr_ptr_q == '1) begin
				wrapped_q <= 1'b1;
			end
		end
	end

	// an offset row that grows is rewritten in place on the last line
	assign mif.we = row_we;
	assign mif.waddr = row_new ? wr_ptr_q : wr_ptr_q - 1'b1;
	assign mif.wdata = row;
	assign mif.raddr = rd_ptr_q;

	tbr_mem u_mem (
		.clk(pclk),
		.mp(mif.mem)
	);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_vector_is_dest: assert property (norm_we && trc_vec |-> row[TBR_INF_SRCDST])
		else $error("vector row without destination flag");
	a_pc_high_bits: assert property (norm_we |-> mif.wdata[17:16] == trc_pc[17:16])
		else $error("pc bits 17:16 not in info field");
	a_line0_base: assert property (mif.we && mif.waddr == '0 && mode == TBR_MODE_COMP
		|-> mif.wdata[19:18] == TBR_FMT_BASE)
		else $error("line 0 lacks base row");
	a_one_offset_zero: assert property (cmp_we && cmp_row[19:18] == TBR_FMT_ONE
		|-> cmp_row[17:6] == 12'h000)
		else $error("unused offset fields not zero");
	a_misaligned_read: assert property (done && !pwrite && !aligned
		|-> prdata_q == 32'h0000_0000 ##1 $stable(rd_ptr_q) && $stable(half_q))
		else $error("misaligned read leaked data or moved pointer");
	a_armed_hold: assert property (done && !pwrite && arm && !rewind
		|=> rd_ptr_q == $past(rd_ptr_q) && half_q == $past(half_q))
		else $error("pointer moved while armed");
	a_source_zero: assert property (done && !pwrite && paddr == TBR_OFF_DATA && !tsrc
		|-> prdata_q == 32'h0000_0000)
		else $error("data read nonzero with source select clear");
	a_arm_locks: assert property (sess_start |=> !unlocked_q [*2])
		else $error("arm write did not lock buffer");
	a_unlock_oldest: assert property (unlock |=> unlocked_q && !half_q
		&& rd_ptr_q == $past(oldest))
		else $error("unlock did not rewind to oldest line");
	a_line_advance: assert property (advance && half_q && !rewind
		|=> rd_ptr_q == $past(rd_ptr_q) + 1'b1 && !half_q)
		else $error("pointer failed to advance after second word");
	a_first_word_stays: assert property (advance && !half_q && !rewind
		|=> $stable(rd_ptr_q) && half_q)
		else $error("pointer moved after first word");
	a_count_holds: assert property (filled_q && !arm && !sess_start |=> $stable(count_q))
		else $error("line count changed while disarmed");
endmodule : tbr_top

// ===== tbr_pkg.sv
package tbr_pkg;
	localparam int TBR_AW = 6;
	localparam int TBR_CW = 7;
	localparam int TBR_ROW_W = 20;
	localparam int TBR_PC_W = 18;
	localparam logic [7:0] TBR_OFF_CTRL = 8'h00;
	localparam logic [7:0] TBR_OFF_STAT = 8'h04;
	localparam logic [7:0] TBR_OFF_DATA = 8'h08;
	localparam logic [7:0] TBR_OFF_DATA_UP = 8'h0c;
	localparam int TBR_CTRL_ARM = 0;
	localparam int TBR_CTRL_TSRC = 1;
	localparam int TBR_CTRL_MODE = 2;
	localparam logic [3:0] TBR_CTRL_RST = 4'h0;
	localparam int TBR_STAT_WRAP = 8;
	localparam int TBR_STAT_UNLK = 9;
	localparam int TBR_STAT_ARM = 10;
	localparam logic [1:0] TBR_MODE_NORMAL = 2'h0;
	localparam logic [1:0] TBR_MODE_LOOP1 = 2'h1;
	localparam logic [1:0] TBR_MODE_COMP = 2'h2;
	localparam int TBR_INF_SRCDST = 19;
	localparam int TBR_INF_VEC = 18;
	localparam logic [1:0] TBR_FMT_BASE = 2'h0;
	localparam logic [1:0] TBR_FMT_ONE = 2'h1;
	localparam logic [1:0] TBR_FMT_TWO = 2'h2;
	localparam logic [1:0] TBR_FMT_THREE = 2'h3;
endpackage : tbr_pkg

// ===== tbr_mem_if.sv
`timescale 1ns/1ps
interface tbr_mem_if #(parameter int W = 20, parameter int AW = 6);
	logic we;
	logic [AW-1:0] waddr;
	logic [W-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [W-1:0] rdata;
	modport ctl(output we, output waddr, output wdata, output raddr, input rdata);
	modport mem(input we, input waddr, input wdata, input raddr, output rdata);
endinterface : tbr_mem_if

// ===== tbr_mem.sv
`timescale 1ns/1ps
module tbr_mem (
	// clock
	input wire logic clk,
	// ports
	tbr_mem_if.mem mp
);
	import tbr_pkg::*;
	// no reset: contents must survive a system reset
	logic [TBR_ROW_W-1:0] ram [2**TBR_AW];
	always_ff @(posedge clk) begin
		if (mp.we) begin
			ram[mp.waddr] <= mp.wdata;
		end
		mp.rdata <= ram[mp.raddr];
	end
endmodule : tbr_mem

// ===== tbr_cmp.sv
`timescale 1ns/1ps
module tbr_cmp (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// opcode stream
	input wire logic start,
	input wire logic valid,
	input wire logic [tbr_pkg::TBR_PC_W-1:0] pc,
	input wire logic at_line0,
	// row out
	output logic we,
	output logic new_line,
	output logic [tbr_pkg::TBR_ROW_W-1:0] row
);
	import tbr_pkg::*;
	logic [11:0] base_q;
	logic have_q;
	logic [1:0] slots_q;
	logic [11:0] acc_q;
	logic open_line;
	logic need_base;
	logic [5:0] off;
	// offset from the bottom of the 64-address block of the base
	assign off = pc[5:0];
	assign open_line = have_q && (slots_q == 2'h1 || slots_q == 2'h2);
	// line 0 must never start with an offset row
	assign need_base = !have_q || pc[17:6] != base_q || (!open_line && at_line0);
	assign we = valid;
	always_comb begin
		new_line = 1'b1;
		if (need_base) begin
			row = {TBR_FMT_BASE, pc};
		end else if (!open_line) begin
			row = {TBR_FMT_ONE, 12'h000, off};
		end else if (slots_q == 2'h1) begin
			new_line = 1'b0;
			row = {TBR_FMT_TWO, 6'h00, off, acc_q[5:0]};
		end else begin
			new_line = 1'b0;
			row = {TBR_FMT_THREE, off, acc_q};
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			have_q <= 1'b0;
			slots_q <= 2'h0;
			base_q <= 12'h000;
			acc_q <= 12'h000;
		end else if (start) begin
			have_q <= 1'b0;
			slots_q <= 2'h0;
		end else if (valid) begin
			acc_q <= row[11:0];
			if (need_base) begin
				base_q <= pc[17:6];
				have_q <= 1'b1;
				slots_q <= 2'h0;
			end else if (open_line) begin
				slots_q <= slots_q + 2'h1;
			end else begin
				slots_q <= 2'h1;
			end
		end
	end
endmodule : tbr_cmp

// ===== tbr_trc_model.sv
`timescale 1ns/1ps
module tbr_trc_model (
	// clock
	input wire logic pclk,
	// trace events towards the block
	output logic trc_valid,
	output logic [tbr_pkg::TBR_PC_W-1:0] trc_pc,
	output logic trc_dest,
	output logic trc_vec
);
	import tbr_pkg::*;
	initial begin
		trc_valid = 1'b0;
		trc_pc = '0;
		trc_dest = 1'b0;
		trc_vec = 1'b0;
	end
	// one event per call; valid drops between calls so each is taken once
	task emit(input logic [TBR_PC_W-1:0] pc, input logic d, input logic v);
		@(posedge pclk);
		trc_valid <= 1'b1;
		trc_pc <= pc;
		trc_dest <= d;
		trc_vec <= v;
		@(posedge pclk);
		trc_valid <= 1'b0;
		// idle lines flip so a stale address is never mistaken for a new one
		trc_pc <= ~pc;
		trc_dest <= ~d;
		trc_vec <= ~v;
	endtask : emit
endmodule : tbr_trc_model

// ===== test_trace_buffer_format_readout.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_trace_buffer_format_readout;
	import tbr_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, secured = 0;
	logic session_end = 0, pready, pslverr, err, trc_valid, trc_dest, trc_vec;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [3:0] pstrb = 4'hf;
	logic [TBR_PC_W-1:0] trc_pc, p, b;
	logic [19:0] ev [0:69];
	int n_errors = 0, compares = 0, seed = 32'ha073990e;
	always #50 pclk = ~pclk;
	tbr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .trc_valid(trc_valid), .trc_pc(trc_pc),
		.trc_dest(trc_dest), .trc_vec(trc_vec), .session_end(session_end), .secured(secured));
	tbr_trc_model i_trc (.pclk(pclk), .trc_valid(trc_valid), .trc_pc(trc_pc),
		.trc_dest(trc_dest), .trc_vec(trc_vec));
	task give_verdict;
		if (n_errors == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : give_verdict
	// answer taken at the rising edge that sees pready high, released at that edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin n_errors++; give_verdict(); end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [31:0] wd(input logic [19:0] row, input logic h);
		return h ? {28'h0, row[19:16]} : {16'h0, row[15:0]};
	endfunction : wd
	function automatic logic [19:0] nrow(input logic [17:0] pc, input logic d, input logic v);
		return {d | v, v, pc};
	endfunction : nrow
	// fields of a wrapped oldest line that were written after the rollover
	function automatic logic [1:0] fresh(input logic [1:0] fmt);
		return (fmt == TBR_FMT_ONE) ? 2'h1 : (fmt == TBR_FMT_TWO) ? 2'h2 : 2'h0;
	endfunction : fresh
	task rdline(input logic [19:0] row);
		apb(1'b0, TBR_OFF_DATA, 32'h0);
		`CHK(r, wd(row, 1'b0))
		apb(1'b0, TBR_OFF_DATA, 32'h0);
		`CHK(r, wd(row, 1'b1))
	endtask : rdline
	task stop_unlock;
		@(posedge pclk);
		session_end <= 1'b1;
		@(posedge pclk);
		session_end <= 1'b0;
		apb(1'b1, TBR_OFF_DATA, 32'h0);
	endtask : stop_unlock
	initial begin
		#6000000;
		n_errors++;
		give_verdict();
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1'b1, TBR_OFF_CTRL, 32'h7);
		for (int i = 0; i < 70; i++) begin
			p = TBR_PC_W'($random(seed));
			ev[i] = nrow(p, i[0], i[0] & i[1]);
			i_trc.emit(p, i[0] | (i[0] & i[1]), i[0] & i[1]);
		end
		apb(1'b0, TBR_OFF_STAT, 32'h0);
		`CHK(r, 32'h540)
		stop_unlock();
		for (int k = 0; k < 64; k++) rdline(ev[k + 6]);
		apb(1'b0, TBR_OFF_STAT, 32'h0);
		`CHK(r, 32'h340)
		apb(1'b0, 8'h09, 32'h0);
		`CHK({err, r}, {1'b1, 32'h0})
		apb(1'b0, TBR_OFF_DATA, 32'h0);
		`CHK(r, wd(ev[6], 1'b0))
		apb(1'b1, TBR_OFF_DATA_UP, 32'h0);
		apb(1'b0, TBR_OFF_DATA, 32'h0);
		`CHK(r, wd(ev[6], 1'b0))
		secured <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1'b0, TBR_OFF_DATA, 32'h0);
		`CHK(r, 32'h0)
		secured <= 1'b0;
		repeat (3) @(posedge pclk);
		apb(1'b0, TBR_OFF_DATA, 32'h0);
		`CHK(r, wd(ev[6], 1'b1))
		apb(1'b1, TBR_OFF_CTRL, 32'h0);
		apb(1'b0, TBR_OFF_DATA, 32'h0);
		`CHK(r, 32'h0)
		apb(1'b1, TBR_OFF_CTRL, 32'h2);
		apb(1'b0, TBR_OFF_DATA, 32'h0);
		`CHK(r, wd(ev[7], 1'b0))
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1'b1, TBR_OFF_CTRL, 32'h2);
		apb(1'b1, TBR_OFF_DATA, 32'h0);
		rdline(ev[6]);
		apb(1'b0, TBR_OFF_STAT, 32'h0);
		`CHK(r, 32'h340)
		apb(1'b1, TBR_OFF_CTRL, 32'h3);
		apb(1'b0, TBR_OFF_DATA, 32'h0);
		`CHK(r, 32'h0)
		apb(1'b0, TBR_OFF_STAT, 32'h0);
		`CHK(r, 32'h400)
		ev[0] = nrow(18'h30001, 1'b0, 1'b0);
		ev[1] = nrow(18'h12345, 1'b1, 1'b0);
		ev[2] = nrow(18'h2abcd, 1'b1, 1'b1);
		for (int j = 0; j < 3; j++) i_trc.emit(ev[j][17:0], ev[j][19], ev[j][18]);
		stop_unlock();
		for (int j = 0; j < 3; j++) rdline(ev[j]);
		apb(1'b1, TBR_OFF_CTRL, 32'hb);
		p = TBR_PC_W'($random(seed));
		b = {p[17:6], 6'h00};
		i_trc.emit(b + 18'd3, 1'b0, 1'b0);
		i_trc.emit(b + 18'd4, 1'b0, 1'b0);
		i_trc.emit(b + 18'd9, 1'b0, 1'b0);
		i_trc.emit(b + 18'd12, 1'b0, 1'b0);
		i_trc.emit(b + 18'd20, 1'b0, 1'b0);
		i_trc.emit(b ^ 18'h20005, 1'b0, 1'b0);
		stop_unlock();
		apb(1'b0, TBR_OFF_STAT, 32'h0);
		`CHK(r, 32'h204)
		rdline({TBR_FMT_BASE, b + 18'd3});
		rdline({TBR_FMT_THREE, 6'd12, 6'd9, 6'd4});
		rdline({TBR_FMT_ONE, 12'h000, 6'd20});
		rdline({TBR_FMT_BASE, b ^ 18'h20005});
		// compressed rollover: 65 base rows wrap onto line 0, then an offset line
		apb(1'b1, TBR_OFF_CTRL, 32'hb);
		for (int j = 0; j < 65; j++) i_trc.emit({12'(j + 1), 6'h07}, 1'b0, 1'b0);
		i_trc.emit({12'd65, 6'h0a}, 1'b0, 1'b0);
		i_trc.emit({12'd65, 6'h0b}, 1'b0, 1'b0);
		stop_unlock();
		apb(1'b0, TBR_OFF_STAT, 32'h0);
		`CHK(r, 32'h340)
		for (int k = 0; k < 63; k++) begin
			rdline({TBR_FMT_BASE, 12'(k + 3), 6'h07});
			if (k == 0) `CHK(fresh(r[3:2]), 2'h0)
		end
		rdline({TBR_FMT_TWO, 6'h00, 6'h0b, 6'h0a});
		give_verdict();
	end
endmodule : test_trace_buffer_format_readout
